// File: mdsc_display_ctrl.v
`timescale 1ns/1ps
`include "mdsc_map.vh"
// Contract
// - fatal error forces meter and display fatal
// - charging stop enters summary
// - charging holds unless fatal or stop
// - charging short presses step both lines
// - charging long presses ignored
// - every button action lights backlight
// - summary rotates every fixed ten seconds
// - summary billing upper, informative lower, label
// - summary upper long goes normal
// - summary rotation repeats eighteen times
// - summary short presses step both lines
// - logbook lists in order, read only
// - logbook entry changes only by buttons
// - logbook view shows five lines
// - logbook short steps, lower long ignored
// - logbook upper long exits, fatal return
// - fatal lower long shows logbook only
// - fatal state persists until power off
// - fatal rotates billing, status word, label
// - fatal refuses charging start requests
// - charging rotates with default five seconds
// - normal lower long logbook, upper selftest
// - fatal short steps top line only
module mdsc_display_ctrl #(
	parameter [31:0] BACKLIGHT_CYC = `MDSC_BACKLIGHT_S * `MDSC_CLK_HZ,
	parameter [31:0] CHG_ROT_CYC = `MDSC_CHG_ROT_S * `MDSC_CLK_HZ,
	parameter [31:0] SUM_ROT_CYC = `MDSC_SUM_ROT_S * `MDSC_CLK_HZ,
	parameter [31:0] FATAL_ROT_CYC = `MDSC_FATAL_ROT_S * `MDSC_CLK_HZ,
	parameter [31:0] LONG_CYC = `MDSC_LONG_MS * `MDSC_CYC_PER_MS
) (
	input wire ref_clk,
	input wire rst_n,
	input wire btn_up_pin,
	input wire btn_down_pin,
	input wire charge_start,
	input wire charge_stop,
	input wire fatal_error,
	input wire selftest_done,
	input wire [15:0] log_count,
	output wire charge_start_ok,
	output reg charge_start_refused,
	output reg [2:0] disp_state,
	output reg meter_fatal,
	output reg [1:0] head_label,
	output reg [3:0] upper_idx,
	output reg [4:0] lower_idx,
	output reg lower_mode,
	output reg [15:0] log_idx,
	output reg log_view,
	output reg backlight
);
	// ****************************************
	// button front end
	// ****************************************
	// each button has its own synchroniser and classifier; the two never
	// interact, so holding both at once yields two independent actions
	// the threshold is shared so both buttons feel the same to the user
	wire up_short, up_long, dn_short, dn_long;

	mdsc_button #(.LONG_CYC(LONG_CYC)) u_up (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.btn_pin(btn_up_pin),
		.short_press(up_short),
		.long_press(up_long)
	);

	mdsc_button #(.LONG_CYC(LONG_CYC)) u_dn (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.btn_pin(btn_down_pin),
		.short_press(dn_short),
		.long_press(dn_long)
	);

	// ****************************************
	// helper functions
	// ****************************************
	// both value lists wrap at either end, as a rotating display should
	// the upper list holds the billing values and never changes in length
	function [3:0] up_step;
		input [3:0] idx;
		input fwd;
		begin
			if (fwd)
				up_step = (idx == `MDSC_UPPER_COUNT - 4'h1) ? 4'h0 : idx + 4'h1;
			else
				up_step = (idx == 4'h0) ? `MDSC_UPPER_COUNT - 4'h1 : idx - 4'h1;
		end
	endfunction

	// the lower list is longer and also steps by itself during rotation
	function [4:0] low_step;
		input [4:0] idx;
		input fwd;
		begin
			if (fwd)
				low_step = (idx == `MDSC_LOWER_COUNT - 5'h01) ? 5'h00 : idx + 5'h01;
			else
				low_step = (idx == 5'h00) ? `MDSC_LOWER_COUNT - 5'h01 : idx - 5'h01;
		end
	endfunction

	// logbook entries wrap at both ends of the stored count
	function [15:0] log_step;
		input [15:0] idx;
		input [15:0] count;
		input fwd;
		begin
			if (fwd)
				log_step = (idx == count - 16'h0001) ? 16'h0000 : idx + 16'h0001;
			else
				log_step = (idx == 16'h0000) ? count - 16'h0001 : idx - 16'h0001;
		end
	endfunction

	// ****************************************
	// state and timers
	// ****************************************
	// counters are full width so that real second-long periods still fit
	reg [2:0] disp_state_next;
	reg log_from_fatal_reg;
	reg [31:0] rot_reg;
	reg [31:0] bl_reg;
	reg [4:0] iter_reg;
	wire any_btn;
	wire [31:0] rot_period;
	wire rot_tick;
	reg rot_wrap;

	assign any_btn = up_short | up_long | dn_short | dn_long;
	// fatal meter can never start charging
	assign charge_start_ok = charge_start & !meter_fatal & !fatal_error;
	// each rotating screen keeps its own period; the summary, charging
	// and fatal periods may all be set at build time
	assign rot_period = (disp_state == `MDSC_ST_SUMMARY) ? SUM_ROT_CYC :
		(disp_state == `MDSC_ST_FATAL) ? FATAL_ROT_CYC : CHG_ROT_CYC;
	assign rot_tick = (rot_reg == rot_period - 32'h0000_0001);

	// ****************************************
	// next display state
	// ****************************************
	// a fatal report outranks every button and session event in the same
	// cycle; once the meter is fatal only the logbook detour stays open, and
	// that detour always leads back to the fatal screen
	always @* begin
		disp_state_next = disp_state;
		if (fatal_error && !meter_fatal) begin
			disp_state_next = `MDSC_ST_FATAL;
		end else begin
			case (disp_state)
			`MDSC_ST_NORMAL: begin
				// a session start outranks a long press landing in the same cycle
				if (charge_start_ok)
					disp_state_next = `MDSC_ST_CHARGING;
				else if (dn_long)
					disp_state_next = `MDSC_ST_LOGBOOK;
				else if (up_long)
					disp_state_next = `MDSC_ST_SELFTEST;
			end
			`MDSC_ST_CHARGING: begin
				// long presses deliberately absent here
				// rotation and taps are handled by the index logic below
				if (charge_stop)
					disp_state_next = `MDSC_ST_SUMMARY;
			end
			`MDSC_ST_SUMMARY: begin
				// the last rotation ends the summary without any button
				if (up_long)
					disp_state_next = `MDSC_ST_NORMAL;
				else if (rot_tick && iter_reg == `MDSC_SUM_ITER - 5'h01)
					disp_state_next = `MDSC_ST_NORMAL;
			end
			`MDSC_ST_LOGBOOK: begin
				if (up_long)
					disp_state_next = log_from_fatal_reg ? `MDSC_ST_FATAL : `MDSC_ST_NORMAL;
			end
			`MDSC_ST_FATAL: begin
				// upper long press falls through on purpose: fatal has no way out
				if (dn_long)
					disp_state_next = `MDSC_ST_LOGBOOK;
			end
			`MDSC_ST_SELFTEST: begin
				// the self test screens themselves live outside this block;
				// it only waits for the done pulse
				if (selftest_done)
					disp_state_next = `MDSC_ST_NORMAL;
			end
			default: disp_state_next = `MDSC_ST_NORMAL;
			endcase
		end
	end

	// rotation advances the upper list when the lower list is also wrapping
	always @* begin
		rot_wrap = (lower_idx == `MDSC_LOWER_COUNT - 5'h01);
	end

	// ****************************************
	// state, flags and meter state
	// ****************************************
	// meter_fatal is the meter's own state, disp_state only the screen;
	// the two part ways only while a fatal meter shows its logbook
	// meter_fatal has no clear at all apart from reset
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			disp_state <= `MDSC_ST_NORMAL;
			meter_fatal <= 1'b0;
			log_from_fatal_reg <= 1'b0;
			charge_start_refused <= 1'b0;
		end else begin
			disp_state <= disp_state_next;
			// a one-cycle refusal lets the core retry later without a clear
			charge_start_refused <= charge_start & (meter_fatal | fatal_error);
			if (fatal_error)
				meter_fatal <= 1'b1;
			if (disp_state_next == `MDSC_ST_LOGBOOK && disp_state != `MDSC_ST_LOGBOOK)
				log_from_fatal_reg <= (disp_state == `MDSC_ST_FATAL);
			// a fault that lands inside the logbook must send the exit back to fatal
			if (fatal_error && disp_state == `MDSC_ST_LOGBOOK)
				log_from_fatal_reg <= 1'b1;
		end
	end

	// ****************************************
	// rotation timer runs in charging, summary and fatal; never in logbook
	// ****************************************
	// one shared counter serves all three rotating screens; it restarts on
	// every state change so each screen opens with a full first period
	// iter_reg counts finished periods and only matters in the summary
	// limitation: periods are fixed at build time, nothing reloads them
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rot_reg <= 32'h0000_0000;
			iter_reg <= 5'h00;
		end else if (disp_state_next != disp_state) begin
			rot_reg <= 32'h0000_0000;
			iter_reg <= 5'h00;
		end else if (disp_state == `MDSC_ST_CHARGING || disp_state == `MDSC_ST_SUMMARY ||
			disp_state == `MDSC_ST_FATAL) begin
			if (rot_tick) begin
				rot_reg <= 32'h0000_0000;
				iter_reg <= iter_reg + 5'h01;
			end else begin
				rot_reg <= rot_reg + 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// value indices: taps step both lines together in charging and summary, top only in fatal
	// ****************************************
	// a press outranks a rotation tick in the same cycle, so a tap is never
	// swallowed by the timer; that tick is simply skipped
	// entering any screen restarts both lists at their first value
	// outside fatal, the upper list only advances on rotation once the lower list wraps
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			upper_idx <= 4'h0;
			lower_idx <= 5'h00;
			log_idx <= 16'h0000;
		end else if (disp_state_next != disp_state) begin
			upper_idx <= 4'h0;
			lower_idx <= 5'h00;
			if (disp_state_next == `MDSC_ST_LOGBOOK)
				log_idx <= 16'h0000; // start at first stored entry
		end else begin
			case (disp_state)
			`MDSC_ST_CHARGING, `MDSC_ST_SUMMARY: begin
				if (up_short || dn_short) begin
					upper_idx <= up_step(upper_idx, up_short);
					lower_idx <= low_step(lower_idx, up_short);
				end else if (rot_tick) begin
					lower_idx <= low_step(lower_idx, 1'b1);
					if (rot_wrap)
						upper_idx <= up_step(upper_idx, 1'b1);
				end
			end
			`MDSC_ST_FATAL: begin
				if (up_short || dn_short)
					upper_idx <= up_step(upper_idx, up_short);
				else if (rot_tick)
					upper_idx <= up_step(upper_idx, 1'b1);
			end
			`MDSC_ST_LOGBOOK: begin
				// only presses move the entry; lower long is ignored
				// an empty logbook leaves the index parked at entry zero;
				// the stored entries themselves are never touched from here
				if (up_short && log_count != 16'h0000)
					log_idx <= log_step(log_idx, log_count, 1'b1);
				else if (dn_short && log_count != 16'h0000)
					log_idx <= log_step(log_idx, log_count, 1'b0);
			end
			default: begin
				// normal and self test keep their indices parked
				upper_idx <= upper_idx;
			end
			endcase
		end
	end

	// ****************************************
	// headline label, lower line mode and logbook five-line view
	// ****************************************
	// face outputs follow the next state so they switch on the same edge as
	// disp_state and never show one cycle of the previous screen
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			head_label <= `MDSC_LBL_NONE;
			lower_mode <= `MDSC_LOW_VALUE;
			log_view <= 1'b0;
		end else begin
			log_view <= (disp_state_next == `MDSC_ST_LOGBOOK);
			lower_mode <= (disp_state_next == `MDSC_ST_FATAL) ? `MDSC_LOW_STATUS : `MDSC_LOW_VALUE;
			case (disp_state_next)
			`MDSC_ST_CHARGING: head_label <= `MDSC_LBL_CHARGING;
			`MDSC_ST_SUMMARY: head_label <= `MDSC_LBL_SUMMARY;
			`MDSC_ST_FATAL: head_label <= `MDSC_LBL_FATAL;
			default: head_label <= `MDSC_LBL_NONE;
			endcase
		end
	end

	// ****************************************
	// backlight retriggers on every press, cheap one counter
	// ****************************************
	// a new press reloads the full period rather than adding to it
	// the lamp goes dark one cycle after the count reaches zero
	// long presses count as actions too, even where they change nothing else
	// trade-off: one down counter instead of a prescaled seconds timer
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			bl_reg <= 32'h0000_0000;
			backlight <= 1'b0;
		end else if (any_btn) begin
			bl_reg <= BACKLIGHT_CYC - 32'h0000_0001;
			backlight <= 1'b1;
		end else if (bl_reg != 32'h0000_0000) begin
			bl_reg <= bl_reg - 32'h0000_0001;
		end else begin
			backlight <= 1'b0;
		end
	end
endmodule // mdsc_display_ctrl

// File: mdsc_map.vh
`ifndef MDSC_MAP_VH
`define MDSC_MAP_VH
// ****************************************
// display state codes
// ****************************************
`define MDSC_ST_NORMAL 3'h0
`define MDSC_ST_CHARGING 3'h1
`define MDSC_ST_SUMMARY 3'h2
`define MDSC_ST_LOGBOOK 3'h3
`define MDSC_ST_FATAL 3'h4
`define MDSC_ST_SELFTEST 3'h5
// ****************************************
// headline label codes
// ****************************************
`define MDSC_LBL_NONE 2'h0
`define MDSC_LBL_CHARGING 2'h1
`define MDSC_LBL_SUMMARY 2'h2
`define MDSC_LBL_FATAL 2'h3
// ****************************************
// value lists and lower line modes
// ****************************************
`define MDSC_UPPER_COUNT 4'h3
`define MDSC_LOWER_COUNT 5'h16
`define MDSC_LOW_VALUE 1'b0
`define MDSC_LOW_STATUS 1'b1
// ****************************************
// timing
// ****************************************
`define MDSC_CLK_HZ 25000000
`define MDSC_MS_PER_S 1000
`define MDSC_CYC_PER_MS 25000
`define MDSC_BACKLIGHT_S 5
`define MDSC_CHG_ROT_S 5
`define MDSC_SUM_ROT_S 10
`define MDSC_FATAL_ROT_S 5
`define MDSC_SUM_ITER 5'h12
`define MDSC_LONG_MS 1000
`define MDSC_DEBOUNCE_MS 20
`endif

// File: mdsc_button.v
`timescale 1ns/1ps
`include "mdsc_map.vh"
// ****************************************
// button synchroniser and press classifier
// ****************************************
module mdsc_button #(
	parameter [31:0] LONG_CYC = `MDSC_LONG_MS * `MDSC_CYC_PER_MS
) (
	input wire ref_clk,
	input wire rst_n,
	input wire btn_pin,
	output reg short_press,
	output reg long_press
);
	reg s1_reg, s2_reg, s3_reg;
	reg pressed_reg;
	reg long_done_reg;
	reg [31:0] hold_reg;

	// three stage sync; a change counts once stages two and three agree
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= btn_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// long fires while held so the user sees the reaction without releasing
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pressed_reg <= 1'b0;
			long_done_reg <= 1'b0;
			hold_reg <= 32'h0000_0000;
			short_press <= 1'b0;
			long_press <= 1'b0;
		end else begin
			short_press <= 1'b0;
			long_press <= 1'b0;
			if (s2_reg == s3_reg)
				pressed_reg <= s3_reg;
			if (pressed_reg) begin
				if (hold_reg != LONG_CYC)
					hold_reg <= hold_reg + 32'h0000_0001;
				if (hold_reg == LONG_CYC - 32'h0000_0001 && !long_done_reg) begin
					long_press <= 1'b1;
					long_done_reg <= 1'b1;
				end
				if (s2_reg == s3_reg && !s3_reg) begin
					short_press <= !long_done_reg;
					hold_reg <= 32'h0000_0000;
					long_done_reg <= 1'b0;
				end
			end
		end
	end
endmodule // mdsc_button

// File: mdsc_btn_model.sv
`timescale 1ns/1ps
// ****
// pushbutton model, high while pressed
// ****
module mdsc_btn_model (
	input wire ref_clk,
	output logic btn_up_pin,
	output logic btn_down_pin
);
	// released buttons rest low
	initial begin
		btn_up_pin = 1'b0;
		btn_down_pin = 1'b0;
	end
	// hold one button a number of cycles; syncs settle before the next press
	task press(input logic up, input int hold);
		@(negedge ref_clk);
		if (up) btn_up_pin = 1'b1; else btn_down_pin = 1'b1;
		repeat (hold) @(negedge ref_clk);
		btn_up_pin = 1'b0;
		btn_down_pin = 1'b0;
		repeat (8) @(negedge ref_clk);
	endtask
endmodule // mdsc_btn_model

// File: mdsc_monitor.sv
`timescale 1ns/1ps
// ****
// display state checker
// ****
module mdsc_monitor (
	input wire ref_clk,
	input wire rst_n,
	input wire charge_start,
	input wire charge_stop,
	input wire fatal_error,
	input wire charge_start_ok,
	input wire charge_start_refused,
	input wire [2:0] disp_state,
	input wire meter_fatal,
	input wire [1:0] head_label,
	input wire [3:0] upper_idx,
	input wire [4:0] lower_idx,
	input wire lower_mode,
	input wire log_view
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// session requests as seen in a settled state
	sequence s_go; disp_state == 3'h0 && charge_start && !fatal_error && !meter_fatal; endsequence
	sequence s_stop; disp_state == 3'h1 && charge_stop && !fatal_error; endsequence
	a_fatal_entry: assert property ($rose(fatal_error) |=> meter_fatal && disp_state == 3'h4)
		else $error("fatal error not entered");
	a_fatal_sticky: assert property (meter_fatal |=> meter_fatal)
		else $error("fatal flag dropped");
	a_fatal_view: assert property (meter_fatal |-> disp_state inside {3'h3, 3'h4})
		else $error("fatal meter left fatal views");
	a_fatal_face: assert property (disp_state == 3'h4 |-> head_label == 2'h3 && lower_mode)
		else $error("fatal screen wrong");
	a_start_refuse: assert property (charge_start && meter_fatal |=> charge_start_refused)
		else $error("start not refused");
	a_start_block: assert property (meter_fatal |-> !charge_start_ok)
		else $error("start accepted while fatal");
	a_chg_enter: assert property (s_go |=> disp_state == 3'h1 && head_label == 2'h1)
		else $error("charging not entered");
	a_chg_hold: assert property (disp_state == 3'h1 && !charge_stop && !fatal_error |=> disp_state == 3'h1)
		else $error("charging left early");
	a_stop_sum: assert property (s_stop |=> disp_state == 3'h2 && head_label == 2'h2)
		else $error("summary not entered");
	a_log_lines: assert property (disp_state == 3'h3 |-> log_view)
		else $error("logbook view off");
	a_idx_range: assert property (upper_idx < 4'h3 && lower_idx < 5'h16)
		else $error("value index out of list");
endmodule // mdsc_monitor

// File: testbench.sv
`timescale 1ns/1ps
// ****
// display controller bench
// ****
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic charge_start = 1'b0;
	logic charge_stop = 1'b0;
	logic fatal_error = 1'b0;
	logic selftest_done = 1'b0;
	logic [15:0] log_count = 16'h0004;
	wire btn_up_pin, btn_down_pin, charge_start_ok, charge_start_refused, meter_fatal, lower_mode, log_view, backlight;
	wire [2:0] disp_state;
	wire [1:0] head_label;
	wire [3:0] upper_idx;
	wire [4:0] lower_idx;
	wire [15:0] log_idx;
	int miscompares = 0;
	int samples_checked = 0;
	always #20 ref_clk = ~ref_clk;
	mdsc_btn_model u_btn (.ref_clk(ref_clk), .btn_up_pin(btn_up_pin), .btn_down_pin(btn_down_pin));
	// short counts keep the run brief
	mdsc_display_ctrl #(.BACKLIGHT_CYC(32'h28), .CHG_ROT_CYC(32'h32), .SUM_ROT_CYC(32'h64), .FATAL_ROT_CYC(32'h1e),
		.LONG_CYC(32'h14)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .btn_up_pin(btn_up_pin), .btn_down_pin(btn_down_pin),
		.charge_start(charge_start), .charge_stop(charge_stop), .fatal_error(fatal_error), .selftest_done(selftest_done),
		.log_count(log_count), .charge_start_ok(charge_start_ok), .charge_start_refused(charge_start_refused),
		.disp_state(disp_state), .meter_fatal(meter_fatal), .head_label(head_label), .upper_idx(upper_idx),
		.lower_idx(lower_idx), .lower_mode(lower_mode), .log_idx(log_idx), .log_view(log_view), .backlight(backlight));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		if (miscompares == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one-cycle request pulse between falling edges
	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask
	task t_charge;
		pulse(charge_start);
		check(head_label, 2'h1);
		u_btn.press(1'b1, 30);
		check(disp_state, 3'h1);
		u_btn.press(1'b1, 5);
		check(backlight, 1'b1);
		check({upper_idx, lower_idx}, {4'h1, 5'h01});
		repeat (60) @(negedge ref_clk);
		check(backlight, 1'b0);
		pulse(charge_stop);
		check(head_label, 2'h2);
	endtask
	task t_sum_auto;
		repeat (1780) @(negedge ref_clk);
		check(disp_state, 3'h2);
		check({upper_idx, lower_idx}, {4'h0, 5'h11});
		repeat (40) @(negedge ref_clk);
		check(disp_state, 3'h0);
	endtask
	task t_sum_exit;
		pulse(charge_start);
		pulse(charge_stop);
		u_btn.press(1'b1, 5);
		check(disp_state, 3'h2);
		check({upper_idx, lower_idx}, {4'h1, 5'h01});
		u_btn.press(1'b0, 5);
		check({upper_idx, lower_idx}, {4'h0, 5'h00});
		u_btn.press(1'b1, 30);
		check(disp_state, 3'h0);
	endtask
	task t_logbook;
		u_btn.press(1'b0, 30);
		check({disp_state, log_idx}, {3'h3, 16'h0000});
		u_btn.press(1'b1, 5);
		check(log_idx, 16'h0001);
		repeat (200) @(negedge ref_clk);
		check(log_idx, 16'h0001);
		u_btn.press(1'b0, 5);
		check(log_idx, 16'h0000);
		u_btn.press(1'b0, 5);
		check(log_idx, 16'h0003);
		u_btn.press(1'b0, 30);
		check(disp_state, 3'h3);
		u_btn.press(1'b1, 30);
		check(disp_state, 3'h0);
	endtask
	task t_selftest;
		u_btn.press(1'b1, 30);
		check(disp_state, 3'h5);
		pulse(selftest_done);
		check(disp_state, 3'h0);
	endtask
	task t_fatal;
		pulse(fatal_error);
		check({meter_fatal, disp_state, head_label, lower_mode}, {1'b1, 3'h4, 2'h3, 1'b1});
		@(negedge ref_clk);
		charge_start = 1'b1;
		#1;
		check(charge_start_ok, 1'b0);
		@(negedge ref_clk);
		charge_start = 1'b0;
		check(charge_start_refused, 1'b1);
		u_btn.press(1'b1, 30);
		check(disp_state, 3'h4);
		u_btn.press(1'b0, 30);
		check({meter_fatal, disp_state}, {1'b1, 3'h3});
		u_btn.press(1'b1, 30);
		check(disp_state, 3'h4);
		u_btn.press(1'b1, 5);
		check({upper_idx, lower_idx}, {4'h1, 5'h00});
	endtask
	// reset for twelve cycles, then the scenarios in turn
	initial begin
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_charge;
		t_sum_auto;
		t_sum_exit;
		t_logbook;
		t_selftest;
		t_fatal;
		close_out;
	end
	// the scenarios need about two thousand six hundred cycles; a hang ends the run
	initial begin
		#800000;
		miscompares++;
		close_out;
	end
endmodule // testbench
bind mdsc_display_ctrl mdsc_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .charge_start(charge_start),
	.charge_stop(charge_stop), .fatal_error(fatal_error), .charge_start_ok(charge_start_ok),
	.charge_start_refused(charge_start_refused), .disp_state(disp_state), .meter_fatal(meter_fatal),
	.head_label(head_label), .upper_idx(upper_idx), .lower_idx(lower_idx), .lower_mode(lower_mode),
	.log_view(log_view));
